// >>> include/rc_delay_identifier_defines.svh
// Purpose: Constants for the RC delay identifier
// Assumes: 40 MHz system clock stands in for the main clock
// Notes:   Counter widths and field positions
`ifndef RC_DELAY_IDENTIFIER_DEFINES_SVH
`define RC_DELAY_IDENTIFIER_DEFINES_SVH

`define RCD_CNT_W        16
`define RCD_CNT_MAX      16'hffff
`define RCD_CNT_ZERO     16'h0000
`define RCD_SEL_W        2
`define RCD_SEL_FULL     2'h0
`define RCD_SEL_DIV2     2'h1
`define RCD_SEL_DIV4     2'h2
`define RCD_SEL_DIV8     2'h3
`define RCD_PRE_W        3
`define RCD_FILT_TICKS   3
`define RCD_FILT_W       2

`endif

// >>> include/rc_delay_identifier_pkg.sv
// Purpose: Types for the RC delay identifier
// Assumes: Constants come from the defines header
// Notes:   Control and status travel as packed structs
`include "rc_delay_identifier_defines.svh"

package rc_delay_identifier_pkg;

    typedef enum logic [2:0] {
        PH_RESET,
        PH_ARMED,
        PH_DISCHARGE,
        PH_CHARGE,
        PH_DONE
    } phase_t;

    typedef struct packed {
        logic                     enable;
        logic                     start;
        logic [`RCD_SEL_W-1:0]    clock_set;
    } ctrl_t;

    typedef struct packed {
        logic discharge_complete_flag;
        logic measurement_error_flag;
        logic done;
    } status_t;

    typedef struct packed {
        phase_t                   phase;
        logic [`RCD_CNT_W-1:0]    count;
        logic [`RCD_CNT_W-1:0]    result;
        logic [`RCD_PRE_W-1:0]    prescale;
        logic [`RCD_FILT_W-1:0]   filt_cnt;
        logic                     filt_level;
        status_t                  status;
        logic                     pin_oe;
        logic                     clock_req;
        logic                     irq;
    } state_t;

endpackage : rc_delay_identifier_pkg

// >>> rtl/rc_delay_identifier.sv
// Purpose: Single-pin RC delay identification unit
// Assumes: Comparator output is synchronous to sys_clk_i
// Notes:   Control bits are plain ports; no register bus
//
// What this block does
// - System reset returns all state and outputs to defaults.
// - Measurement-done interrupt pulses when the done flag becomes one.
// - Clock request stays high from arming until measurement finishes.
// - One 16-bit counter times discharge, then charge, at selected rate.
// - Comparator passes a three-clock glitch filter before use.
// - Charge phase counts ticks until filtered pin exceeds threshold.
// - Reset phase: flags zero, pin undriven, lowest power.
// - Armed phase requests clock, clears counter, no drive, no counting.
// - Discharge pulls pin low, counts to all ones, sets complete flag.
// - Pin above threshold at discharge end sets the error flag.
// - After discharge, move to charge, release pin, restart counter.
// - Threshold crossing in charge stops counter and captures result.
// - Charge counter hitting all ones sets error and stops.
// - Stop enters done, sets done, lowest power, until reset phase.
// - Time base from main clock; select zero counts every clock.
// - Select 0,1,2,3 divides the clock by 1,2,4,8.
// - Clearing enable returns to reset phase and clears all flags.
// - Result output holds the captured 16-bit count.
`timescale 1ns/1ps
`include "rc_delay_identifier_defines.svh"

module rc_delay_identifier (
    // Clock and reset
    input  wire logic                                  sys_clk_i,
    input  wire logic                                  sys_rst_i,
    // Control
    input  wire rc_delay_identifier_pkg::ctrl_t        ctrl_i,
    // Threshold comparator on the sense pin
    input  wire logic                                  rc_sense_pin_i,
    // Sense pin drive, low when enabled
    output logic                                       rc_sense_pin_o,
    output logic                                       rc_sense_pin_oe_o,
    // Status and result
    output rc_delay_identifier_pkg::status_t           status_o,
    output rc_delay_identifier_pkg::phase_t            phase_o,
    output logic [`RCD_CNT_W-1:0]                      result_o,
    output logic                                       measurement_done_irq_o,
    output logic                                       clock_req_o
);

    rc_delay_identifier_pkg::state_t st_reg;
    rc_delay_identifier_pkg::state_t st_next;

    logic                    tick;
    logic [`RCD_PRE_W-1:0]   div_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Time base divider
    always_comb begin
        case (ctrl_i.clock_set)
            `RCD_SEL_FULL: div_mask = 3'h0;
            `RCD_SEL_DIV2: div_mask = 3'h1;
            `RCD_SEL_DIV4: div_mask = 3'h3;
            `RCD_SEL_DIV8: div_mask = 3'h7;
            default:        div_mask = 3'h0;
        endcase
        tick = ((st_reg.prescale & div_mask) == div_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next     = st_reg;
        st_next.irq = 1'b0;

        // Filter: level changes only after three agreeing samples
        if (rc_sense_pin_i == st_reg.filt_level) begin
            st_next.filt_cnt = '0;
        end else if (st_reg.filt_cnt == 2'(`RCD_FILT_TICKS - 1)) begin
            st_next.filt_cnt   = '0;
            st_next.filt_level = rc_sense_pin_i;
        end else begin
            st_next.filt_cnt = st_reg.filt_cnt + 2'h1;
        end

        if (st_reg.phase == rc_delay_identifier_pkg::PH_DISCHARGE ||
            st_reg.phase == rc_delay_identifier_pkg::PH_CHARGE) begin
            st_next.prescale = st_reg.prescale + 3'h1;
        end else begin
            st_next.prescale = '0;
        end

        case (st_reg.phase)
            rc_delay_identifier_pkg::PH_RESET: begin
                st_next.status    = '0;
                st_next.pin_oe    = 1'b0;
                st_next.clock_req = 1'b0;
                if (ctrl_i.enable && !ctrl_i.start) begin
                    st_next.phase     = rc_delay_identifier_pkg::PH_ARMED;
                    st_next.clock_req = 1'b1;
                    st_next.count     = `RCD_CNT_ZERO;
                end
            end
            rc_delay_identifier_pkg::PH_ARMED: begin
                st_next.count = `RCD_CNT_ZERO;
                if (ctrl_i.start) begin
                    st_next.phase  = rc_delay_identifier_pkg::PH_DISCHARGE;
                    st_next.pin_oe = 1'b1;
                end
            end
            rc_delay_identifier_pkg::PH_DISCHARGE: begin
                if (tick) begin
                    if (st_reg.count == `RCD_CNT_MAX) begin
                        st_next.status.discharge_complete_flag = 1'b1;
                        if (st_reg.filt_level) begin
                            st_next.status.measurement_error_flag = 1'b1;
                        end
                        st_next.phase  = rc_delay_identifier_pkg::PH_CHARGE;
                        st_next.pin_oe = 1'b0;
                        st_next.count  = `RCD_CNT_ZERO;
                    end else begin
                        st_next.count = st_reg.count + 16'h1;
                    end
                end
            end
            rc_delay_identifier_pkg::PH_CHARGE: begin
                if (st_reg.filt_level) begin
                    st_next.result = st_reg.count;
                    st_next.phase  = rc_delay_identifier_pkg::PH_DONE;
                end else if (tick) begin
                    if (st_reg.count == `RCD_CNT_MAX) begin
                        st_next.status.measurement_error_flag = 1'b1;
                        st_next.result = st_reg.count;
                        st_next.phase  = rc_delay_identifier_pkg::PH_DONE;
                    end else begin
                        st_next.count = st_reg.count + 16'h1;
                    end
                end
                if (st_next.phase == rc_delay_identifier_pkg::PH_DONE) begin
                    st_next.status.done = 1'b1;
                    st_next.irq         = 1'b1;
                    st_next.clock_req   = 1'b0;
                end
            end
            rc_delay_identifier_pkg::PH_DONE: begin
                st_next.clock_req = 1'b0;
            end
            default: begin
                st_next.phase = rc_delay_identifier_pkg::PH_RESET;
            end
        endcase

        if (!ctrl_i.enable) begin
            st_next.phase     = rc_delay_identifier_pkg::PH_RESET;
            st_next.status    = '0;
            st_next.pin_oe    = 1'b0;
            st_next.clock_req = 1'b0;
            st_next.irq       = 1'b0;
            st_next.count     = `RCD_CNT_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rc_sense_pin_o         = 1'b0;
    assign rc_sense_pin_oe_o      = st_reg.pin_oe;
    assign status_o               = st_reg.status;
    assign phase_o                = st_reg.phase;
    assign result_o               = st_reg.result;
    assign measurement_done_irq_o = st_reg.irq;
    assign clock_req_o            = st_reg.clock_req;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_discharge_end;
        st_reg.phase == rc_delay_identifier_pkg::PH_DISCHARGE && tick && st_reg.count == `RCD_CNT_MAX
            && ctrl_i.enable;
    endsequence

    sequence s_charge_timeout;
        st_reg.phase == rc_delay_identifier_pkg::PH_CHARGE && !st_reg.filt_level && tick
            && st_reg.count == `RCD_CNT_MAX && ctrl_i.enable;
    endsequence

    a_reset_phase_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st_reg.phase == rc_delay_identifier_pkg::PH_RESET |-> !rc_sense_pin_oe_o && !clock_req_o)
        else $error("reset phase not quiet");

    a_done_irq_pulse: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(status_o.done) |-> measurement_done_irq_o)
        else $error("done without interrupt");

    a_clock_req_held: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_reg.phase == rc_delay_identifier_pkg::PH_DISCHARGE ||
         st_reg.phase == rc_delay_identifier_pkg::PH_CHARGE) |-> clock_req_o)
        else $error("clock request dropped mid measurement");

    a_discharge_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st_reg.phase == rc_delay_identifier_pkg::PH_DISCHARGE |-> rc_sense_pin_oe_o && !rc_sense_pin_o)
        else $error("pin not pulled low in discharge");

    a_to_charge_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s_discharge_end |=> st_reg.phase == rc_delay_identifier_pkg::PH_CHARGE
            && st_reg.count == `RCD_CNT_ZERO && status_o.discharge_complete_flag && !rc_sense_pin_oe_o)
        else $error("discharge end mishandled");

    a_capture_value: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_reg.phase == rc_delay_identifier_pkg::PH_CHARGE && st_reg.filt_level && ctrl_i.enable)
            |=> result_o == $past(st_reg.count) && status_o.done)
        else $error("result not captured");

    a_enable_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        !ctrl_i.enable |=> st_reg.phase == rc_delay_identifier_pkg::PH_RESET && status_o == '0)
        else $error("enable clear ignored");

    a_full_rate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_reg.phase == rc_delay_identifier_pkg::PH_DISCHARGE && ctrl_i.clock_set == `RCD_SEL_FULL
            && st_reg.count != `RCD_CNT_MAX && ctrl_i.enable) |=> st_reg.count == $past(st_reg.count) + 16'h1)
        else $error("full rate count missed");

    a_done_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_reg.phase == rc_delay_identifier_pkg::PH_DONE && ctrl_i.enable)
            |=> st_reg.phase == rc_delay_identifier_pkg::PH_DONE && !clock_req_o)
        else $error("done phase left without reset");

    a_filter_delay: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $changed(st_reg.filt_level) |-> $past(rc_sense_pin_i, 1) == st_reg.filt_level
            && $past(rc_sense_pin_i, 2) == st_reg.filt_level && $past(rc_sense_pin_i, 3) == st_reg.filt_level)
        else $error("filter passed a glitch");

    // Phase and flag checks
    a_discharge_error: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s_discharge_end |=> status_o.measurement_error_flag == $past(st_reg.filt_level))
        else $error("discharge error flag wrong");

    a_charge_timeout: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        s_charge_timeout |=> st_reg.phase == rc_delay_identifier_pkg::PH_DONE && status_o.measurement_error_flag
            && result_o == `RCD_CNT_MAX && status_o.done)
        else $error("charge timeout mishandled");

    a_charge_count: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_reg.phase == rc_delay_identifier_pkg::PH_CHARGE && !st_reg.filt_level && tick
            && st_reg.count != `RCD_CNT_MAX && ctrl_i.enable) |=> st_reg.count == $past(st_reg.count) + 16'h1)
        else $error("charge count missed a tick");

    a_count_steady: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_reg.phase == rc_delay_identifier_pkg::PH_DISCHARGE && !tick && ctrl_i.enable) |=> $stable(st_reg.count))
        else $error("count moved without a tick");

    a_slow_rate: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_reg.phase == rc_delay_identifier_pkg::PH_DISCHARGE && ctrl_i.clock_set == `RCD_SEL_DIV8
            && st_reg.prescale != 3'h7 && ctrl_i.enable) |=> $stable(st_reg.count))
        else $error("slow rate counted early");

    a_irq_single: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        measurement_done_irq_o |=> !measurement_done_irq_o)
        else $error("interrupt longer than one cycle");

    a_irq_source: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        measurement_done_irq_o |-> $rose(status_o.done))
        else $error("interrupt without done");

    a_armed_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st_reg.phase == rc_delay_identifier_pkg::PH_ARMED
            |-> clock_req_o && !rc_sense_pin_oe_o && st_reg.count == `RCD_CNT_ZERO)
        else $error("armed phase not prepared");

    a_refuse_start: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_reg.phase == rc_delay_identifier_pkg::PH_RESET && ctrl_i.start)
            |=> st_reg.phase == rc_delay_identifier_pkg::PH_RESET)
        else $error("start accepted out of order");

    a_done_quiet: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st_reg.phase == rc_delay_identifier_pkg::PH_DONE
            |-> status_o.done && !clock_req_o && !rc_sense_pin_oe_o)
        else $error("done phase not quiet");

    a_charge_release: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st_reg.phase == rc_delay_identifier_pkg::PH_CHARGE |-> !rc_sense_pin_oe_o && status_o.discharge_complete_flag)
        else $error("charge phase pin or flag wrong");

    a_reset_flags: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        st_reg.phase == rc_delay_identifier_pkg::PH_RESET |-> status_o == '0)
        else $error("flags set in reset phase");

    a_filter_hold: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (rc_sense_pin_i == st_reg.filt_level) |=> $stable(st_reg.filt_level))
        else $error("filter moved on agreeing input");

    a_result_holds: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        (st_reg.phase != rc_delay_identifier_pkg::PH_CHARGE) |=> $stable(result_o))
        else $error("result changed outside capture");

endmodule : rc_delay_identifier

// >>> testbench/rc_network_model.sv
// Purpose: Behavioural RC network and comparator on the sense pin
// Assumes: Comparator output is sampled on sys_clk_i
// Notes:   Output rises a set number of cycles after the pin is released
`timescale 1ns/1ps

module rc_network_model (
    // Clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    // Pin drive and charge time
    input  wire logic        drive_low_i,
    input  wire logic [15:0] rise_cycles_i,
    // Comparator output
    output logic             above_o
);
    logic [15:0] cnt_reg;

    // Pull-up holds the idle pin above threshold
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_reg <= 16'h0000;
            above_o <= 1'b1;
        end else if (drive_low_i) begin
            cnt_reg <= 16'h0000;
            above_o <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg == 16'hffff) ? cnt_reg : cnt_reg + 16'h0001;
            above_o <= above_o | ((cnt_reg + 16'h0001) >= rise_cycles_i);
        end
    end
endmodule : rc_network_model

// >>> testbench/rc_delay_identifier_tb.sv
// Purpose: Self-checking bench for the RC delay identifier
// Assumes: 40 MHz clock, inputs driven 2 ns after the rising edge
// Notes:   One full measurement at full rate plus refusals and aborts
`timescale 1ns/1ps

module rc_delay_identifier_tb;
    logic                           sys_clk_i   = 1'b0;
    logic                           sys_rst_i   = 1'b1;
    rc_delay_identifier_pkg::ctrl_t ctrl_i      = '0;
    logic [15:0]                    rise_cycles = 16'h0040;
    logic                           rc_sense_pin_i, rc_sense_pin_o, rc_sense_pin_oe_o;
    logic                           measurement_done_irq_o, clock_req_o;
    rc_delay_identifier_pkg::status_t status_o;
    rc_delay_identifier_pkg::phase_t  phase_o;
    logic [15:0]                    result_o;
    logic [18:0]                    exp_q[$];
    int                             n_errors = 0;
    int                             n_compared = 0;
    int                             cycles = 0;
    int                             n;

    always #12.5 sys_clk_i = ~sys_clk_i;

    rc_delay_identifier dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ctrl_i(ctrl_i),
        .rc_sense_pin_i(rc_sense_pin_i), .rc_sense_pin_o(rc_sense_pin_o),
        .rc_sense_pin_oe_o(rc_sense_pin_oe_o), .status_o(status_o), .phase_o(phase_o),
        .result_o(result_o), .measurement_done_irq_o(measurement_done_irq_o), .clock_req_o(clock_req_o));

    rc_network_model u_rc (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .drive_low_i(rc_sense_pin_oe_o & ~rc_sense_pin_o), .rise_cycles_i(rise_cycles), .above_o(rc_sense_pin_i));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic tally(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : tally

    task automatic check_state(input rc_delay_identifier_pkg::phase_t p, input logic [2:0] st,
                               input logic oe, input logic req);
        tally({24'h0, phase_o, status_o, rc_sense_pin_oe_o, clock_req_o}, {24'h0, p, st, oe, req});
    endtask : check_state

    task automatic check_meas(input logic [18:0] got, input logic [18:0] exp);
        tally({13'h0, got}, {13'h0, exp});
    endtask : check_meas

    // Apply one control setting, then let the given number of edges pass
    task automatic drive(input logic en, input logic st, input logic [1:0] sel, input int waits);
        @(posedge sys_clk_i);
        #2 ctrl_i = {en, st, sel};
        repeat (waits) @(posedge sys_clk_i);
        #1;
    endtask : drive

    task automatic wait_phase(input rc_delay_identifier_pkg::phase_t p, input int limit, output int k);
        k = 0;
        while (phase_o !== p && k < limit) begin
            @(posedge sys_clk_i);
            #1;
            k++;
        end
    endtask : wait_phase

    ////////////////////////////////////////////////////////////////////////////////
    // Result monitor: each interrupt pulse takes the oldest expected note
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            summarize();
        end
        #1;
        if (measurement_done_irq_o === 1'b1) begin
            if (exp_q.size() == 0)
                tally(32'h1, 32'h0);
            else
                check_meas({status_o, result_o}, exp_q.pop_front());
        end
    end

    initial begin
        void'($urandom(91));
        rise_cycles = 16'($urandom_range(500, 10));
        repeat (5) @(posedge sys_clk_i);
        #2 sys_rst_i = 1'b0;
        #1 check_state(rc_delay_identifier_pkg::PH_RESET, 3'h0, 1'b0, 1'b0);
        check_meas({3'h0, result_o}, 19'h0);
        drive(1'b1, 1'b1, 2'h0, 1);
        check_state(rc_delay_identifier_pkg::PH_RESET, 3'h0, 1'b0, 1'b0);
        drive(1'b0, 1'b0, 2'h0, 1);
        for (int s = 1; s < 4; s++) begin
            drive(1'b1, 1'b0, s[1:0], 1);
            check_state(rc_delay_identifier_pkg::PH_ARMED, 3'h0, 1'b0, 1'b1);
            drive(1'b0, 1'b0, 2'h0, 1);
            check_state(rc_delay_identifier_pkg::PH_RESET, 3'h0, 1'b0, 1'b0);
        end
        // Full measurement at full rate; settling wait is 300 us
        drive(1'b1, 1'b0, 2'h0, 12000);
        exp_q.push_back({3'b101, rise_cycles + 16'h0003});
        drive(1'b1, 1'b1, 2'h0, 1);
        check_state(rc_delay_identifier_pkg::PH_DISCHARGE, 3'h0, 1'b1, 1'b1);
        tally({31'h0, rc_sense_pin_o}, 32'h0);
        wait_phase(rc_delay_identifier_pkg::PH_CHARGE, 70000, n);
        tally(n, 32'd65536);
        check_state(rc_delay_identifier_pkg::PH_CHARGE, 3'b100, 1'b0, 1'b1);
        wait_phase(rc_delay_identifier_pkg::PH_DONE, 1000, n);
        check_state(rc_delay_identifier_pkg::PH_DONE, 3'b101, 1'b0, 1'b0);
        drive(1'b1, 1'b1, 2'h0, 3);
        check_state(rc_delay_identifier_pkg::PH_DONE, 3'b101, 1'b0, 1'b0);
        drive(1'b0, 1'b0, 2'h0, 1);
        check_state(rc_delay_identifier_pkg::PH_RESET, 3'h0, 1'b0, 1'b0);
        check_meas({3'h0, result_o}, {3'h0, rise_cycles + 16'h0003});
        tally(exp_q.size(), 32'h0);
        // Abort in mid-discharge at the slowest rate
        drive(1'b1, 1'b0, 2'h3, 12000);
        drive(1'b1, 1'b1, 2'h3, 40);
        check_state(rc_delay_identifier_pkg::PH_DISCHARGE, 3'h0, 1'b1, 1'b1);
        drive(1'b0, 1'b0, 2'h0, 1);
        check_state(rc_delay_identifier_pkg::PH_RESET, 3'h0, 1'b0, 1'b0);
        summarize();
    end
endmodule : rc_delay_identifier_tb
